// ==== rtl/epiu_unit.sv ====
// external pin interrupt unit: pin filters, triggers, event routing, wake-up
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps

`include "epiu_cfg.svh"

module epiu_unit
  import epiu_pkg::*;
(
  input  wire logic                            mclk,          // peripheral clock
  input  wire logic                            nrst,          // sync reset, active low
  input  wire logic                            ce,            // clock enable
  input  wire logic [`EPIU_ADDR_W-1:0]         addr,          // register byte address
  input  wire logic [31:0]                     wdata,         // write data
  input  wire logic                            wr,            // write strobe
  input  wire logic                            rd,            // read strobe
  output logic      [31:0]                     rdata,         // read data, next cycle
  input  wire logic [`EPIU_NUM_IRQ-1:0]        irqPin,        // ordinary request pins
  input  wire logic [`EPIU_NUM_IRQ-1:0]        dsPin,         // deep-standby-wake pins
  input  wire logic                            nmiPin,        // non-maskable pin
  input  wire logic                            oscStop,       // main oscillator stopped
  input  wire logic                            wdtErr,        // watchdog fault
  input  wire logic                            iwdtErr,       // independent watchdog fault
  input  wire logic                            lvd1Evt,       // voltage detector one
  input  wire logic                            lvd2Evt,       // voltage detector two
  input  wire logic                            parityErr,     // sram parity error
  input  wire logic                            eccErr,        // sram ecc error
  input  wire logic                            busSlvErr,     // bus slave error
  input  wire logic                            busMstErr,     // bus master error
  input  wire logic                            spMonErr,      // stack pointer monitor
  input  wire logic [`EPIU_PERIPH_NUM-1:0]     periphEvt,     // events 64..511
  input  wire epiu_pm_t                        powerMode,     // current power state
  output logic      [`EPIU_NUM_SLOT-1:0]       nvicReq,       // to core controller
  output logic                                 dtcTrig,       // transfer controller start
  output logic                                 dmaTrig,       // memory engine start
  output logic                                 nmiReq,        // non-maskable request
  output logic                                 wakeReq        // leave low-power mode
);

  // ***********************************************************
  // helpers
  // ***********************************************************

  // sample strobe from the shared prescaler
  // one strobe every 1, 8, 32 or 64 clocks, all in phase
  function automatic logic sampleTick(input logic [1:0] sel,
                                      input logic [`EPIU_PRESC_W-1:0] cnt);
    logic t;
    t = 1'b1;
    case (sel)
      `EPIU_FCLK_DIV1:  t = 1'b1;
      `EPIU_FCLK_DIV8:  t = (cnt & `EPIU_DIV8_MASK) == '0;
      `EPIU_FCLK_DIV32: t = (cnt & `EPIU_DIV32_MASK) == '0;
      `EPIU_FCLK_DIV64: t = (cnt & `EPIU_DIV64_MASK) == '0;
      default:          t = 1'b1;
    endcase
    return t;
  endfunction

  // true when the address falls into a word range
  // low address bits must be zero, so byte offsets miss
  function automatic logic inRange(input logic [`EPIU_ADDR_W-1:0] a,
                                   input logic [`EPIU_ADDR_W-1:0] lo,
                                   input logic [`EPIU_ADDR_W-1:0] hi);
    return (a >= lo) && (a <= hi) && (a[1:0] == 2'h0);
  endfunction

  epiu_state_t                     s;
  epiu_state_t                     next_s;
  logic [`EPIU_EVT_NUM-1:0]        evtVec;
  logic [`EPIU_NUM_NMI_SRC-1:0]    nmiSet;
  logic                            anyIrq;

  // ***********************************************************
  // latency of a pin change
  // ***********************************************************
  // edge 1 and 2: the two synchroniser flops
  // edge 3: filtered level, or two ticks later with filter on
  // edge 4: event from the trigger detector, one cycle in the edge modes
  // edge 5: slot, engine and wake outputs
  // limitation: the prescaler is shared and free-running, so the
  // filter delay of a divided channel varies by up to one period

  // ***********************************************************
  // event list seen by the router
  // ***********************************************************

  // numbers 17..63 are unused here and read as idle
  // channel n raises event n+1, so number zero stays idle
  always_comb
  begin
    evtVec = '0;
    evtVec[`EPIU_IRQ_EVT_HI:`EPIU_IRQ_EVT_LO] = s.irqEvt;
    evtVec[`EPIU_EVT_NUM-1:`EPIU_PERIPH_FIRST] = periphEvt;
  end

  // ***********************************************************
  // next state
  // ***********************************************************

  always_comb
  begin
    logic                          raw;
    logic                          tick;
    logic [`EPIU_FLT_SAMPLES-1:0]  sh;
    logic                          lvl;
    logic                          prv;
    logic [`EPIU_ADDR_W-1:0]       idx;
    logic [`EPIU_NUM_NMI_SRC-1:0]  clr;
    raw    = 1'b1;
    tick   = 1'b0;
    sh     = '0;
    lvl    = 1'b0;
    prv    = 1'b0;
    idx    = '0;
    clr    = '0;
    nmiSet = '0;
    anyIrq = 1'b0;
    next_s = s;

    // two-flop synchronisers on every pin
    // only the second flop is read; the first may be metastable
    next_s.sync1Irq = irqPin;
    next_s.sync2Irq = s.sync1Irq;
    next_s.sync1Ds  = dsPin;
    next_s.sync2Ds  = s.sync1Ds;
    next_s.sync1Nmi = nmiPin;
    next_s.sync2Nmi = s.sync1Nmi;
    next_s.presc    = s.presc + 1'b1;

    // filter per channel; index 16 is the non-maskable pin
    for (int i = 0; i < `EPIU_NUM_FLT; i++)
    begin
      // an unselected channel reads idle high and never fires
      if (i == `EPIU_NMI_IDX)
        raw = s.sync2Nmi;
      else if (s.iselN[i])
        raw = s.sync2Irq[i];
      else if (s.iselDs[i])
        raw = s.sync2Ds[i];
      else
        raw = 1'b1;
      tick = sampleTick(s.ctrl[i][`EPIU_F_FCLK_HI:`EPIU_F_FCLK_LO], s.presc);
      sh = s.samp[i];
      if (tick)
        sh = {s.samp[i][`EPIU_FLT_SAMPLES-2:0], raw};
      next_s.samp[i] = sh;

      // with the filter on, level moves only after three equal samples
      if (s.ctrl[i][`EPIU_F_FILTER_ENABLE_BIT])
      begin
        if (sh == '1)
          next_s.filt[i] = 1'b1;
        else if (sh == '0)
          next_s.filt[i] = 1'b0;
      end
      else
        next_s.filt[i] = raw;
      next_s.prevLvl[i] = s.filt[i];
    end

    // trigger detection on the filtered level
    // edge modes compare with last cycle's level: one pulse per edge
    for (int i = 0; i < `EPIU_NUM_IRQ; i++)
    begin
      lvl = s.filt[i];
      prv = s.prevLvl[i];
      case (epiu_det_t'(s.ctrl[i][`EPIU_F_DET_HI:`EPIU_F_DET_LO]))
        DET_LOW:  next_s.irqEvt[i] = ~lvl;
        DET_FALL: next_s.irqEvt[i] = prv & ~lvl;
        DET_RISE: next_s.irqEvt[i] = ~prv & lvl;
        DET_BOTH: next_s.irqEvt[i] = prv ^ lvl;
        default:  next_s.irqEvt[i] = 1'b0;
      endcase
    end

    // non-maskable pin edge and fault sources
    // all of them land in one sticky status word
    lvl = s.filt[`EPIU_NMI_IDX];
    prv = s.prevLvl[`EPIU_NMI_IDX];
    if (s.ctrl[`EPIU_NMI_IDX][`EPIU_NMI_RISE_BIT])
      nmiSet[`EPIU_N_PIN] = ~prv & lvl;
    else
      nmiSet[`EPIU_N_PIN] = prv & ~lvl;
    nmiSet[`EPIU_N_OSC]    = oscStop;
    nmiSet[`EPIU_N_WDT]    = wdtErr;
    nmiSet[`EPIU_N_INDEPENDENT_WATCHDOG]   = iwdtErr;
    nmiSet[`EPIU_N_LOW_VOLTAGE_DETECTOR_ONE]   = lvd1Evt;
    nmiSet[`EPIU_N_LOW_VOLTAGE_DETECTOR_TWO]   = lvd2Evt;
    nmiSet[`EPIU_N_PARITY] = parityErr;
    nmiSet[`EPIU_N_ECC]    = eccErr;
    nmiSet[`EPIU_N_BUSS]   = busSlvErr;
    nmiSet[`EPIU_N_BUSM]   = busMstErr;
    nmiSet[`EPIU_N_SPMON]  = spMonErr;

    // register writes
    // misaligned or unmapped writes change nothing
    if (wr)
    begin
      if (inRange(addr, `EPIU_A_CTRL_BASE, `EPIU_A_CTRL_LAST))
      begin
        idx = (addr - `EPIU_A_CTRL_BASE) >> 2;
        next_s.ctrl[idx] = wdata[`EPIU_CTRL_W-1:0] & `EPIU_CTRL_MASK;
      end
      if (inRange(addr, `EPIU_A_SLOT_BASE, `EPIU_A_SLOT_LAST))
      begin
        idx = (addr - `EPIU_A_SLOT_BASE) >> 2;
        next_s.slotSel[idx] = wdata[`EPIU_EVT_W-1:0];
      end
      case (addr)
        `EPIU_A_NMI_CTRL: next_s.ctrl[`EPIU_NMI_IDX] = wdata[`EPIU_CTRL_W-1:0] & `EPIU_NMI_MASK;
        `EPIU_A_INT_INPUT_SELECT_BIT:     next_s.iselN  = wdata[`EPIU_NUM_IRQ-1:0];
        `EPIU_A_INT_INPUT_SELECT_BIT_DS:  next_s.iselDs = wdata[`EPIU_NUM_IRQ-1:0];
        `EPIU_A_WAKEUP_ENABLE_REG:    next_s.wakeup_enable_reg  = wdata[`EPIU_NUM_IRQ-1:0];
        `EPIU_A_SNZSEL:   next_s.snzSel = wdata[`EPIU_NUM_IRQ-1:0];
        `EPIU_A_NMI_STAT: clr           = wdata[`EPIU_NUM_NMI_SRC-1:0];
        `EPIU_A_DTC_SEL:  next_s.dtcSel = wdata[`EPIU_EVT_W-1:0];
        `EPIU_A_DMA_SEL:  next_s.dmaSel = wdata[`EPIU_EVT_W-1:0];
        default:          ;
      endcase
    end

    // write-one-to-clear, a new event in the same cycle wins
    // so a fault arriving during the clear is never lost
    next_s.nmiStat = (s.nmiStat & ~clr) | nmiSet;
    next_s.nmiReq  = |next_s.nmiStat;

    // slot routing; number zero selects nothing
    // slots and both engines see the same event vector; wake reads nvicReq and irqEvt
    for (int k = 0; k < `EPIU_NUM_SLOT; k++)
      next_s.nvicReq[k] = evtVec[s.slotSel[k]];
    next_s.dtcTrig = evtVec[s.dtcSel];
    next_s.dmaTrig = evtVec[s.dmaSel];

    // wake-up decision per power state
    // run mode never wakes; deep wake sees only wake-pin channels
    anyIrq = (|s.nvicReq) | (|s.irqEvt);
    case (powerMode)
      PM_SLEEP:   next_s.wakeReq = s.nmiReq | anyIrq;
      PM_STANDBY: next_s.wakeReq = s.nmiReq | (|(s.irqEvt & s.wakeup_enable_reg));
      PM_SNOOZE:  next_s.wakeReq = s.nmiReq
                                   | (|(s.irqEvt & s.wakeup_enable_reg & s.snzSel));
      PM_DEEP:    next_s.wakeReq = |(s.irqEvt & s.iselDs);
      default:    next_s.wakeReq = 1'b0;
    endcase

    // register reads, answered in the following cycle
    // unmapped reads answer zero; the word stands one cycle
    next_s.rdata = '0;
    if (rd)
    begin
      if (inRange(addr, `EPIU_A_CTRL_BASE, `EPIU_A_CTRL_LAST))
      begin
        idx = (addr - `EPIU_A_CTRL_BASE) >> 2;
        next_s.rdata[`EPIU_CTRL_W-1:0] = s.ctrl[idx];
      end
      if (inRange(addr, `EPIU_A_SLOT_BASE, `EPIU_A_SLOT_LAST))
      begin
        idx = (addr - `EPIU_A_SLOT_BASE) >> 2;
        next_s.rdata[`EPIU_EVT_W-1:0] = s.slotSel[idx];
      end
      case (addr)
        `EPIU_A_NMI_CTRL: next_s.rdata[`EPIU_CTRL_W-1:0] = s.ctrl[`EPIU_NMI_IDX];
        `EPIU_A_INT_INPUT_SELECT_BIT:     next_s.rdata[`EPIU_NUM_IRQ-1:0] = s.iselN;
        `EPIU_A_INT_INPUT_SELECT_BIT_DS:  next_s.rdata[`EPIU_NUM_IRQ-1:0] = s.iselDs;
        `EPIU_A_WAKEUP_ENABLE_REG:    next_s.rdata[`EPIU_NUM_IRQ-1:0] = s.wakeup_enable_reg;
        `EPIU_A_SNZSEL:   next_s.rdata[`EPIU_NUM_IRQ-1:0] = s.snzSel;
        `EPIU_A_NMI_STAT: next_s.rdata[`EPIU_NUM_NMI_SRC-1:0] = s.nmiStat;
        `EPIU_A_LEVELS:   next_s.rdata[`EPIU_NUM_FLT-1:0] = s.filt;
        `EPIU_A_DTC_SEL:  next_s.rdata[`EPIU_EVT_W-1:0] = s.dtcSel;
        `EPIU_A_DMA_SEL:  next_s.rdata[`EPIU_EVT_W-1:0] = s.dmaSel;
        default:          ;
      endcase
    end
  end

  // ***********************************************************
  // state register
  // ***********************************************************

  // reset: pins unselected, filters off, routing idle, request-pin levels idle high, nmi level low
  // ce low holds every flop outside reset, synchronisers and read word included
  always_ff @(posedge mclk)
  begin
    if (!nrst)
    begin
      // a zero level would read as low and fake an event after reset
      s <= '0;
      s.sync1Irq <= '1;
      s.sync2Irq <= '1;
      s.sync1Ds <= '1;
      s.sync2Ds <= '1;
      s.samp[`EPIU_NUM_IRQ-1:0] <= '1;
      s.filt[`EPIU_NUM_IRQ-1:0] <= '1;
      s.prevLvl[`EPIU_NUM_IRQ-1:0] <= '1;
    end
    else if (ce)
      s <= next_s;
  end

  // outputs straight from the state flops
  // no logic after the flops, so nothing glitches outward
  assign rdata   = s.rdata;
  assign nvicReq = s.nvicReq;
  assign dtcTrig = s.dtcTrig;
  assign dmaTrig = s.dmaTrig;
  assign nmiReq  = s.nmiReq;
  assign wakeReq = s.wakeReq;

endmodule

// ==== rtl/epiu_cfg.svh ====
// constants of the external pin interrupt unit: map, fields, widths
`ifndef EPIU_CFG_SVH
`define EPIU_CFG_SVH

// ***********************************************************
// sizes
// ***********************************************************
`define EPIU_NUM_IRQ      16
`define EPIU_NUM_FLT      17
`define EPIU_NMI_IDX      16
`define EPIU_NUM_SLOT     96
`define EPIU_NUM_NMI_SRC  11
`define EPIU_EVT_W        9
`define EPIU_EVT_NUM      512
`define EPIU_PERIPH_FIRST 64
`define EPIU_PERIPH_NUM   448
`define EPIU_IRQ_EVT_LO   1
`define EPIU_IRQ_EVT_HI   16
`define EPIU_ADDR_W       12
`define EPIU_PRESC_W      6

// ***********************************************************
// register byte offsets
// ***********************************************************
`define EPIU_A_CTRL_BASE  12'h000
`define EPIU_A_CTRL_LAST  12'h03C
`define EPIU_A_NMI_CTRL   12'h040
`define EPIU_A_INT_INPUT_SELECT_BIT       12'h044
`define EPIU_A_INT_INPUT_SELECT_BIT_DS    12'h048
`define EPIU_A_WAKEUP_ENABLE_REG      12'h04C
`define EPIU_A_SNZSEL     12'h050
`define EPIU_A_NMI_STAT   12'h054
`define EPIU_A_LEVELS     12'h058
`define EPIU_A_DTC_SEL    12'h05C
`define EPIU_A_DMA_SEL    12'h060
`define EPIU_A_SLOT_BASE  12'h200
`define EPIU_A_SLOT_LAST  12'h37C

// ***********************************************************
// control register fields
// ***********************************************************
`define EPIU_F_DET_LO     0
`define EPIU_F_DET_HI     1
`define EPIU_F_FCLK_LO    4
`define EPIU_F_FCLK_HI    5
`define EPIU_F_FILTER_ENABLE_BIT      7
`define EPIU_CTRL_W       8
`define EPIU_CTRL_MASK    8'hB3
`define EPIU_NMI_MASK     8'hB1
`define EPIU_NMI_RISE_BIT 0

// ***********************************************************
// non-maskable status bit positions
// ***********************************************************
`define EPIU_N_PIN        0
`define EPIU_N_OSC        1
`define EPIU_N_WDT        2
`define EPIU_N_INDEPENDENT_WATCHDOG       3
`define EPIU_N_LOW_VOLTAGE_DETECTOR_ONE       4
`define EPIU_N_LOW_VOLTAGE_DETECTOR_TWO       5
`define EPIU_N_PARITY     6
`define EPIU_N_ECC        7
`define EPIU_N_BUSS       8
`define EPIU_N_BUSM       9
`define EPIU_N_SPMON      10

// ***********************************************************
// filter sampling
// ***********************************************************
`define EPIU_FCLK_DIV1    2'h0
`define EPIU_FCLK_DIV8    2'h1
`define EPIU_FCLK_DIV32   2'h2
`define EPIU_FCLK_DIV64   2'h3
`define EPIU_DIV8_MASK    6'h07
`define EPIU_DIV32_MASK   6'h1F
`define EPIU_DIV64_MASK   6'h3F
`define EPIU_FLT_SAMPLES  3

`endif

// ==== rtl/epiu_pkg.sv ====
// types of the external pin interrupt unit
package epiu_pkg;
  `include "epiu_cfg.svh"

  // trigger choice per channel
  typedef enum logic [1:0] {DET_LOW, DET_FALL, DET_RISE, DET_BOTH} epiu_det_t;

  // power state reported by the power controller
  typedef enum logic [2:0] {PM_RUN, PM_SLEEP, PM_STANDBY, PM_SNOOZE, PM_DEEP} epiu_pm_t;

  typedef struct packed {
    logic [`EPIU_NUM_IRQ-1:0]                       sync1Irq;
    logic [`EPIU_NUM_IRQ-1:0]                       sync2Irq;
    logic [`EPIU_NUM_IRQ-1:0]                       sync1Ds;
    logic [`EPIU_NUM_IRQ-1:0]                       sync2Ds;
    logic                                           sync1Nmi;
    logic                                           sync2Nmi;
    logic [`EPIU_PRESC_W-1:0]                       presc;
    logic [`EPIU_NUM_FLT-1:0][`EPIU_FLT_SAMPLES-1:0] samp;
    logic [`EPIU_NUM_FLT-1:0]                       filt;
    logic [`EPIU_NUM_FLT-1:0]                       prevLvl;
    logic [`EPIU_NUM_FLT-1:0][`EPIU_CTRL_W-1:0]     ctrl;
    logic [`EPIU_NUM_IRQ-1:0]                       iselN;
    logic [`EPIU_NUM_IRQ-1:0]                       iselDs;
    logic [`EPIU_NUM_IRQ-1:0]                       wakeup_enable_reg;
    logic [`EPIU_NUM_IRQ-1:0]                       snzSel;
    logic [`EPIU_NUM_NMI_SRC-1:0]                   nmiStat;
    logic [`EPIU_EVT_W-1:0]                         dtcSel;
    logic [`EPIU_EVT_W-1:0]                         dmaSel;
    logic [`EPIU_NUM_SLOT-1:0][`EPIU_EVT_W-1:0]     slotSel;
    logic [`EPIU_NUM_IRQ-1:0]                       irqEvt;
    logic [`EPIU_NUM_SLOT-1:0]                      nvicReq;
    logic                                           dtcTrig;
    logic                                           dmaTrig;
    logic                                           nmiReq;
    logic                                           wakeReq;
    logic [31:0]                                    rdata;
  } epiu_state_t;
endpackage

// ==== verif/epiu_unit_properties.sv ====
// port assertions of the external pin interrupt unit
`timescale 1ns/1ps
`include "epiu_cfg.svh"

module epiu_unit_properties
  import epiu_pkg::*;
(
  input wire logic                     mclk,      // peripheral clock
  input wire logic                     nrst,      // sync reset, active low
  input wire logic                     ce,        // clock enable
  input wire logic [`EPIU_ADDR_W-1:0]  addr,      // register address
  input wire logic                     wr,        // write strobe
  input wire logic                     rd,        // read strobe
  input wire logic [31:0]              rdata,     // read data
  input wire logic                     oscStop,   // oscillator stopped
  input wire epiu_pm_t                 powerMode, // power state
  input wire logic [`EPIU_NUM_SLOT-1:0] nvicReq,  // core requests
  input wire logic                     nmiReq,    // non-maskable request
  input wire logic                     wakeReq    // wake request
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  // ****************
  // sequences
  // ****************
  // a read taken at one place
  sequence sRead(logic [`EPIU_ADDR_W-1:0] a);
    ce && rd && addr == a;
  endsequence

  // no write while the status travels to the request output
  sequence sCalm;
    ce && !wr && !$past(wr) ##1 ce && !wr;
  endsequence

  // ****************
  // assertions
  // ****************
  fault_to_nmi_a: assert property (ce && oscStop |-> ##[1:3] nmiReq)
    else $error("oscillator stop raised no request");
  nmi_sticky_a: assert property (nmiReq ##0 sCalm |=> nmiReq)
    else $error("request dropped without a clear");
  ctrl_fields_a: assert property (ce && rd && addr <= `EPIU_A_CTRL_LAST
    |=> (rdata & ~32'h000000B3) == 32'h0) else $error("unused control bits read set");
  nmi_fields_a: assert property (sRead(`EPIU_A_NMI_CTRL)
    |=> (rdata & ~32'h000000B1) == 32'h0) else $error("unused nmi control bits read set");
  sel_width_a: assert property (sRead(`EPIU_A_INT_INPUT_SELECT_BIT) |=> rdata[31:16] == 16'h0)
    else $error("select reads beyond sixteen pins");
  run_quiet_a: assert property (ce && powerMode == PM_RUN |=> !wakeReq)
    else $error("wake raised while running");
  sleep_wake_a: assert property (ce && powerMode == PM_SLEEP && (nmiReq || |nvicReq)
    |-> ##[1:2] wakeReq) else $error("sleep not left");
  standby_wake_a: assert property (ce && powerMode == PM_STANDBY && nmiReq
    |-> ##[1:2] wakeReq) else $error("standby not left");
  snooze_wake_a: assert property (ce && powerMode == PM_SNOOZE && nmiReq
    |-> ##[1:2] wakeReq) else $error("snooze not left");
endmodule

// ==== verif/epiu_pin_src.sv ====
// model of the pins that feed the external pin interrupt unit
`timescale 1ns/1ps

module epiu_pin_src
(
  input  wire logic        mclk,    // peripheral clock
  output logic      [15:0] irqPin,  // ordinary request pins
  output logic      [15:0] dsPin,   // deep-standby-wake pins
  output logic             nmiPin   // non-maskable pin
);
  // request pins idle high, nmi idle low
  initial
  begin
    irqPin = 16'hFFFF;
    dsPin  = 16'hFFFF;
    nmiPin = 1'b0;
  end

  // toggle one pin after an edge; only one pin of a number moves
  task automatic flip(input int kind, input int ch);
    @(posedge mclk);
    if (kind == 0)
      irqPin[ch] <= ~irqPin[ch];
    else if (kind == 1)
      dsPin[ch] <= ~dsPin[ch];
    else
      nmiPin <= ~nmiPin;
  endtask

  // pulse of len cycles away from the idle level
  task automatic pulse(input int kind, input int ch, input int len);
    flip(kind, ch);
    repeat (len - 1) @(posedge mclk);
    flip(kind, ch);
  endtask
endmodule

// ==== verif/epiu_unit_tb.sv ====
// self-checking bench of the external pin interrupt unit
`timescale 1ns/1ps
`include "epiu_cfg.svh"

module epiu_unit_tb
  import epiu_pkg::*;
;
  logic         mclk, nrst, ce, wr, rd, nmiPin, dtcTrig, dmaTrig, nmiReq, wakeReq;
  logic [11:0]  addr, ctrlA;
  logic [31:0]  wdata, rdata;
  logic [9:0]   fault;
  logic [15:0]  irqPin, dsPin;
  logic [447:0] periphEvt;
  logic [95:0]  nvicReq, expV;
  logic [95:0]  nvicSeen = '0;
  logic         dtcSeen = 1'b0, dmaSeen = 1'b0, wakeSeen = 1'b0;
  epiu_pm_t     powerMode;
  int           fails = 0, checkCount = 0, cyc = 0, hiCnt = 0, firstHi = -1, pinLow = -1;
  int           ch, k, n, dv, slotEvt [96];

  epiu_unit epiu_unit_i (.mclk, .nrst, .ce, .addr, .wdata, .wr, .rd, .rdata, .irqPin,
    .dsPin, .nmiPin, .oscStop(fault[0]), .wdtErr(fault[1]), .iwdtErr(fault[2]),
    .lvd1Evt(fault[3]), .lvd2Evt(fault[4]), .parityErr(fault[5]), .eccErr(fault[6]),
    .busSlvErr(fault[7]), .busMstErr(fault[8]), .spMonErr(fault[9]), .periphEvt,
    .powerMode, .nvicReq, .dtcTrig, .dmaTrig, .nmiReq, .wakeReq);
  epiu_pin_src epiu_pin_src_i (.mclk, .irqPin, .dsPin, .nmiPin);

  // 10 MHz clock
  initial
  begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // gather what the unit raised; a hang counts as a mismatch
  always @(posedge mclk)
  begin
    cyc      <= cyc + 1;
    hiCnt    <= hiCnt + int'(nvicReq[0] === 1'b1);
    nvicSeen <= nvicSeen | nvicReq;
    dtcSeen  <= dtcSeen | dtcTrig;
    dmaSeen  <= dmaSeen | dmaTrig;
    wakeSeen <= wakeSeen | wakeReq;
    if (nvicReq[0] === 1'b1 && firstHi < 0)
      firstHi <= cyc;
    if (irqPin[ch] === 1'b0 && pinLow < 0)
      pinLow <= cyc;
    if (cyc == 20000)
    begin
      fails++;
      close_out;
    end
  end

  // ****************
  // tasks
  // ****************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // slot selections are mirrored in the model
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    if (a >= `EPIU_A_SLOT_BASE && a <= `EPIU_A_SLOT_LAST)
      slotEvt[(a - `EPIU_A_SLOT_BASE) >> 2] = int'(d[8:0]);
    @(posedge mclk);
    wr <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    @(posedge mclk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk(rdata, e);
  endtask

  // cleared off the edge so the monitor never races it
  task automatic clr;
    @(negedge mclk);
    hiCnt    = 0;
    firstHi  = -1;
    pinLow   = -1;
    nvicSeen = '0;
    dtcSeen  = 1'b0;
    dmaSeen  = 1'b0;
    wakeSeen = 1'b0;
  endtask

  // one pulse, then slot-zero high cycles against the model
  task automatic shot(input int kind, input int len, input int settle, input epiu_pm_t pm,
                      input int e);
    clr;
    @(posedge mclk);
    powerMode <= pm;
    epiu_pin_src_i.pulse(kind, ch, len);
    repeat (settle) @(posedge mclk);
    @(negedge mclk);
    chk(hiCnt, e);
  endtask

  // slot-zero high cycles for a low pulse at the undivided rate
  function automatic int exp_evt(input int det, input int flt, input int len);
    if (flt != 0 && len < 3)
      return 0;
    return det == 0 ? len : det == 3 ? 2 : 1;
  endfunction

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************
  // main sequence
  // ****************
  initial
  begin
    ce        = 1'b1;
    nrst      = 1'b0;
    wr        = 1'b0;
    rd        = 1'b0;
    addr      = '0;
    wdata     = '0;
    fault     = '0;
    periphEvt = '0;
    powerMode = PM_RUN;
    void'($urandom(80266));
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    rchk(`EPIU_A_INT_INPUT_SELECT_BIT, 32'h0);
    wreg(`EPIU_A_CTRL_BASE, 32'hFFFFFFFF);
    rchk(`EPIU_A_CTRL_BASE, 32'hB3);
    wreg(`EPIU_A_NMI_CTRL, 32'hFFFFFFFF);
    rchk(`EPIU_A_NMI_CTRL, 32'hB1);
    wreg(`EPIU_A_INT_INPUT_SELECT_BIT, 32'hFFFFFFFF);
    rchk(`EPIU_A_INT_INPUT_SELECT_BIT, 32'hFFFF);
    rchk(`EPIU_A_LEVELS, 32'hFFFF);
    // frozen clock enable keeps the read word standing
    @(posedge mclk);
    addr <= `EPIU_A_INT_INPUT_SELECT_BIT;
    rd   <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    ce <= 1'b0;
    repeat (3) @(posedge mclk);
    ce <= 1'b1;
    @(negedge mclk);
    chk(rdata, 32'hFFFF);
    rchk(12'h045, 32'h0);
    rchk(12'h100, 32'h0);
    $display("registers done");
    // unselected pin stays quiet, then every detection mode
    ch    = $urandom % 16;
    ctrlA = 12'(`EPIU_A_CTRL_BASE + 4 * ch);
    wreg(`EPIU_A_SLOT_BASE, ch + 1);
    wreg(`EPIU_A_INT_INPUT_SELECT_BIT, 32'h0);
    wreg(ctrlA, 32'h1);
    shot(0, 4, 20, PM_RUN, 0);
    wreg(`EPIU_A_INT_INPUT_SELECT_BIT, 32'h1 << ch);
    for (int d = 0; d < 4; d++)
      for (int f = 0; f < 2; f++)
        for (int l = 2; l < 5; l++)
        begin
          wreg(ctrlA, d | (f << 7));
          shot(0, l, 20, PM_RUN, exp_evt(d, f, l));
        end
    wreg(ctrlA, 32'h1);
    shot(0, 6, 20, PM_RUN, 1);
    chk(firstHi - pinLow, 5);
    wreg(ctrlA, 32'h81);
    shot(0, 6, 20, PM_RUN, 1);
    chk(firstHi - pinLow, 7);
    $display("detection done");
    // divided sampling: two ticks dropped, three kept
    for (int s = 1; s < 4; s++)
    begin
      dv = s == 1 ? 8 : s == 2 ? 32 : 64;
      wreg(ctrlA, 32'h81 | (s << 4));
      shot(0, 2 * dv, 5 * dv, PM_RUN, 0);
      shot(0, 3 * dv, 5 * dv, PM_RUN, 1);
    end
    $display("filter rates done");
    wreg(ctrlA, 32'h1);
    for (int w = 0; w < 6; w++)
    begin
      wreg(`EPIU_A_WAKEUP_ENABLE_REG, 32'(w == 2 || w == 3 || w == 5) << ch);
      wreg(`EPIU_A_SNZSEL, 32'(w > 3) << ch);
      shot(0, 3, 20, w == 0 ? PM_SLEEP : w < 3 ? PM_STANDBY : PM_SNOOZE, 1);
      chk(wakeSeen, w == 0 || w == 2 || w == 5);
    end
    wreg(`EPIU_A_INT_INPUT_SELECT_BIT, 32'h0);
    wreg(`EPIU_A_INT_INPUT_SELECT_BIT_DS, 32'h1 << ch);
    shot(0, 3, 20, PM_RUN, 0);
    shot(1, 3, 20, PM_DEEP, 1);
    chk(wakeSeen, 1);
    $display("wake-up done");
    // nmi pin in both edge modes
    for (int r = 0; r < 2; r++)
    begin
      wreg(`EPIU_A_NMI_CTRL, r);
      epiu_pin_src_i.flip(2, 0);
      repeat (12) @(posedge mclk);
      rchk(`EPIU_A_NMI_STAT, r);
      epiu_pin_src_i.flip(2, 0);
      repeat (12) @(posedge mclk);
      rchk(`EPIU_A_NMI_STAT, 32'h1);
      wreg(`EPIU_A_NMI_STAT, 32'h1);
      rchk(`EPIU_A_NMI_STAT, 32'h0);
    end
    for (int i = 0; i < 10; i++)
    begin
      @(posedge mclk);
      powerMode <= epiu_pm_t'(1 + i % 3);
      fault[i]  <= 1'b1;
      @(posedge mclk);
      fault[i] <= 1'b0;
      repeat (4) @(posedge mclk);
      rchk(`EPIU_A_NMI_STAT, 32'h1 << (i + 1));
      wreg(`EPIU_A_NMI_STAT, 32'h7FF);
    end
    $display("non-maskable done");
    // random peripheral events to a random slot and both engines
    for (int j = 0; j < 4; j++)
    begin
      k = $urandom % 96;
      n = 64 + $urandom % 448;
      wreg(12'(`EPIU_A_SLOT_BASE + 4 * k), n);
      wreg(`EPIU_A_DTC_SEL, n);
      wreg(`EPIU_A_DMA_SEL, n);
      for (int s = 0; s < 96; s++)
        expV[s] = slotEvt[s] == n;
      clr;
      @(posedge mclk);
      powerMode        <= PM_RUN;
      periphEvt[n - 64] <= 1'b1;
      @(posedge mclk);
      periphEvt[n - 64] <= 1'b0;
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk(nvicSeen === expV, 1);
      chk({dtcSeen, dmaSeen}, 2'h3);
      rchk(12'(`EPIU_A_SLOT_BASE + 4 * k), n);
    end
    $display("routing done");
    close_out;
  end
endmodule

bind epiu_unit epiu_unit_properties epiu_unit_properties_i (.mclk, .nrst, .ce, .addr, .wr,
  .rd, .rdata, .oscStop, .powerMode, .nvicReq, .nmiReq, .wakeReq);
